/* core/astbrg_pkg.sv */
// Purpose: constants and types shared by the serial transceiver files
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register
// Notes: Operation list below, one line per behaviour
//
// Operation
// - free-running 16-bit baud timer sets bit pace
// - standard speed: clock over 16 times divisor+1
// - high speed: clock over 4 times divisor+1
// - divisor write clears the baud timer
// - transmit enable raises transmit request
// - idle write reaches shifter through the queue a cycle later
// - enabling with queued character starts at once
// - nine-bit data written only with both low byte lanes
// - transmit request follows selected mode
// - four-entry transmit queue before shifter
// - four-entry receive queue with error flags
// - even, odd or no parity for bytes
// - one or two stop bits each frame
// - address detect keeps only ninth-bit-one characters
// - flag parity, framing and overrun errors
// - parity/data field: 11,10,01,00 encodings
// - stop select one means two stops
// - transmit request mode field encodings
// - disabling transmit aborts and resets queue
package astbrg_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TXDATA = 8'h08;
  localparam logic [7:0] OFS_RXDATA = 8'h0c;
  localparam logic [7:0] OFS_DIVISOR = 8'h10;

  localparam int MODE_STOP = 0;
  localparam int MODE_PDS_LO = 1;
  localparam int MODE_HS = 3;

  localparam int STA_RXDA = 0;
  localparam int STA_OERR = 1;
  localparam int STA_FERR = 2;
  localparam int STA_PERR = 3;
  localparam int STA_RIDLE = 4;
  localparam int STA_ADDEN = 5;
  localparam int STA_TRMT = 8;
  localparam int STA_TXBF = 9;
  localparam int STA_TXEN = 10;
  localparam int STA_IRQM_LO = 13;
  localparam int STA_IRQM_HI = 15;

  localparam logic [15:0] DIVISOR_RST = 16'h0000;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam logic [4:0] OSR_STD = 5'h10;
  localparam logic [4:0] OSR_HS = 5'h04;
  localparam int FIFO_DEPTH = 4;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PDS_8N = 2'b00,
    PDS_8E = 2'b01,
    PDS_8O = 2'b10,
    PDS_9N = 2'b11
  } astbrg_pds_t;

  typedef enum logic [1:0] {
    TXI_EACH = 2'b00,
    TXI_DONE = 2'b01,
    TXI_EMPTY = 2'b10,
    TXI_RSVD = 2'b11
  } astbrg_irqm_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_START = 3'b001,
    S_DATA = 3'b010,
    S_PAR = 3'b011,
    S_STOP = 3'b100
  } astbrg_state_t;

  typedef struct packed {
    logic high_speed_select;
    astbrg_pds_t parity_data_select;
    logic stop_count_select;
  } astbrg_mode_t;

  typedef struct packed {
    logic perr;
    logic ferr;
    logic [8:0] data;
  } astbrg_rx_entry_t;

endpackage : astbrg_pkg

/* core/astbrg_fifo.sv */
// Purpose: small first-in first-out queue with show-ahead output
// Assumes: push ignored when full, pop ignored when empty
// Notes: clear empties the queue in one cycle
`timescale 1ns/10ps
module astbrg_fifo #(
  parameter int W = 9
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic push,
  input wire logic [W-1:0] din,
  input wire logic pop,
  output logic [W-1:0] dout,
  output logic full,
  output logic empty,
  output logic [2:0] count
);
  logic [W-1:0] mem [astbrg_pkg::FIFO_DEPTH];
  logic [1:0] wp;
  logic [1:0] rp;
  logic do_push;
  logic do_pop;

  assign full = (count == 3'(astbrg_pkg::FIFO_DEPTH));
  assign empty = (count == 3'h0);
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign dout = mem[rp];

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wp] <= din;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp <= 2'h0;
      rp <= 2'h0;
      count <= 3'h0;
    end else if (clr) begin
      wp <= 2'h0;
      rp <= 2'h0;
      count <= 3'h0;
    end else begin
      if (do_push) begin
        wp <= wp + 2'h1;
      end
      if (do_pop) begin
        rp <= rp + 2'h1;
      end
      count <= count + 3'(do_push) - 3'(do_pop);
    end
  end
endmodule : astbrg_fifo

/* core/astbrg_top.sv */
// Purpose: full-duplex asynchronous serial transceiver with baud generator
// Assumes: AXI4-Lite slave, single clock, serial input asynchronous
// Notes: transmit request is a one-cycle pulse for an outside controller
`timescale 1ns/10ps
module astbrg_top (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic SERIAL_IN_PIN,
  output logic SERIAL_OUT_PIN,
  output logic SERIAL_OUT_OE,
  output logic TX_IRQ_REQ
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [4:0] osr_of(input logic hs);
    return hs ? astbrg_pkg::OSR_HS : astbrg_pkg::OSR_STD;
  endfunction : osr_of

  function automatic logic par_of(input logic [7:0] d, input astbrg_pkg::astbrg_pds_t p);
    return (p == astbrg_pkg::PDS_8O) ? ~^d : ^d;
  endfunction : par_of

  // ---------------------------------------------------------------
  // registers and bus state
  // ---------------------------------------------------------------
  astbrg_pkg::astbrg_mode_t mode;
  astbrg_pkg::astbrg_irqm_t transmit_irq_mode;
  logic transmit_enable_bit;
  logic txen_q;
  logic adden;
  logic oerr;
  logic [15:0] baud_divisor;
  logic [15:0] baud_cnt;
  logic tick;
  logic [4:0] osr;
  logic nine;
  logic has_par;

  logic aw_pend;
  logic w_pend;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic rd_go;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] rd_val;

  assign osr = osr_of(mode.high_speed_select);
  assign nine = (mode.parity_data_select == astbrg_pkg::PDS_9N);
  assign has_par = (mode.parity_data_select == astbrg_pkg::PDS_8E) ||
                   (mode.parity_data_select == astbrg_pkg::PDS_8O);

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  assign S_AXI_AWREADY = !aw_pend && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_pend && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign wr_go = aw_pend && w_pend && !S_AXI_BVALID;
  assign rd_go = S_AXI_ARVALID && S_AXI_ARREADY;
  assign wr_ok = (aw_addr[1:0] == 2'h0) && (aw_addr <= astbrg_pkg::OFS_DIVISOR);
  assign rd_ok = (S_AXI_ARADDR[1:0] == 2'h0) && (S_AXI_ARADDR <= astbrg_pkg::OFS_DIVISOR);

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      aw_pend <= 1'b0;
      w_pend <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= astbrg_pkg::RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_pend <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_pend <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_pend <= 1'b0;
        w_pend <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? astbrg_pkg::RESP_OKAY : astbrg_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= astbrg_pkg::RESP_OKAY;
    end else if (rd_go) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_ok ? rd_val : 32'h0000_0000;
      S_AXI_RRESP <= rd_ok ? astbrg_pkg::RESP_OKAY : astbrg_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic wr_mode;
  logic wr_status;
  logic wr_div;
  logic rx_ovf;
  assign wr_mode = wr_go && (aw_addr == astbrg_pkg::OFS_MODE) && w_strb[0];
  assign wr_status = wr_go && (aw_addr == astbrg_pkg::OFS_STATUS);
  assign wr_div = wr_go && (aw_addr == astbrg_pkg::OFS_DIVISOR);

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      mode <= astbrg_pkg::MODE_RST;
      transmit_irq_mode <= astbrg_pkg::TXI_EACH;
      transmit_enable_bit <= 1'b0;
      adden <= 1'b0;
      baud_divisor <= astbrg_pkg::DIVISOR_RST;
    end else begin
      if (wr_mode) begin
        mode <= w_data[astbrg_pkg::MODE_HS:astbrg_pkg::MODE_STOP];
      end
      if (wr_status && w_strb[1]) begin
        transmit_irq_mode <= astbrg_pkg::astbrg_irqm_t'({w_data[astbrg_pkg::STA_IRQM_HI],
                                                         w_data[astbrg_pkg::STA_IRQM_LO]});
        transmit_enable_bit <= w_data[astbrg_pkg::STA_TXEN];
      end
      if (wr_status && w_strb[0]) begin
        adden <= w_data[astbrg_pkg::STA_ADDEN];
      end
      if (wr_div) begin
        if (w_strb[0]) baud_divisor[7:0] <= w_data[7:0];
        if (w_strb[1]) baud_divisor[15:8] <= w_data[15:8];
      end
    end
  end

  // overrun is sticky; a new overrun beats a software clear
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      oerr <= 1'b0;
    end else if (rx_ovf) begin
      oerr <= 1'b1;
    end else if (wr_status && w_strb[0] && !w_data[astbrg_pkg::STA_OERR]) begin
      oerr <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // baud timer
  // ---------------------------------------------------------------
  // cleared on divisor write and on enable so the first bit is full length
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      baud_cnt <= 16'h0000;
      txen_q <= 1'b0;
    end else begin
      txen_q <= transmit_enable_bit;
      if (wr_div || (transmit_enable_bit && !txen_q)) begin
        baud_cnt <= 16'h0000;
      end else if (tick) begin
        baud_cnt <= 16'h0000;
      end else begin
        baud_cnt <= baud_cnt + 16'h0001;
      end
    end
  end
  assign tick = (baud_cnt == baud_divisor);

  // ---------------------------------------------------------------
  // transmit path
  // ---------------------------------------------------------------
  astbrg_pkg::astbrg_state_t tx_state;
  logic [8:0] transmit_shift_register;
  logic [8:0] tx_dout;
  logic [4:0] tx_phase;
  logic [3:0] tx_bit;
  logic tx_stop2;
  logic tx_par;
  logic tx_push;
  logic tx_pop;
  logic tx_full;
  logic tx_empty;
  logic [2:0] tx_count;
  logic tx_done;
  logic tx_last;
  logic next_serial_out;

  // nine-bit data needs both low byte lanes in one write
  assign tx_push = wr_go && (aw_addr == astbrg_pkg::OFS_TXDATA) &&
                   (nine ? (w_strb[1:0] == 2'h3) : w_strb[0]);
  assign tx_pop = transmit_enable_bit && (tx_state == astbrg_pkg::S_IDLE) && !tx_empty;
  assign tx_last = tick && (tx_phase == osr - 5'h01);
  assign tx_done = tx_last && (tx_state == astbrg_pkg::S_STOP) &&
                   (!mode.stop_count_select || tx_stop2);

  astbrg_fifo #(
    .W(9)
  ) u_tx_fifo (
    .clk(CLK_SYS),
    .rst(RST),
    .clr(txen_q && !transmit_enable_bit),
    .push(tx_push),
    .din(nine ? w_data[8:0] : {1'b0, w_data[7:0]}),
    .pop(tx_pop),
    .dout(tx_dout),
    .full(tx_full),
    .empty(tx_empty),
    .count(tx_count)
  );

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      tx_state <= astbrg_pkg::S_IDLE;
      transmit_shift_register <= 9'h000;
      tx_phase <= 5'h00;
      tx_bit <= 4'h0;
      tx_stop2 <= 1'b0;
      tx_par <= 1'b0;
    end else if (!transmit_enable_bit) begin
      tx_state <= astbrg_pkg::S_IDLE;
    end else if (tx_pop) begin
      transmit_shift_register <= tx_dout;
      tx_par <= par_of(tx_dout[7:0], mode.parity_data_select);
      tx_state <= astbrg_pkg::S_START;
      tx_phase <= 5'h00;
      tx_bit <= 4'h0;
      tx_stop2 <= 1'b0;
    end else if (tick && tx_state != astbrg_pkg::S_IDLE) begin
      tx_phase <= tx_last ? 5'h00 : tx_phase + 5'h01;
      if (tx_last) begin
        case (tx_state)
          astbrg_pkg::S_START: tx_state <= astbrg_pkg::S_DATA;
          astbrg_pkg::S_DATA: begin
            transmit_shift_register <= transmit_shift_register >> 1;
            tx_bit <= tx_bit + 4'h1;
            if (tx_bit == (nine ? 4'h8 : 4'h7)) begin
              tx_state <= has_par ? astbrg_pkg::S_PAR : astbrg_pkg::S_STOP;
            end
          end
          astbrg_pkg::S_PAR: tx_state <= astbrg_pkg::S_STOP;
          astbrg_pkg::S_STOP: begin
            tx_stop2 <= 1'b1;
            if (tx_done) tx_state <= astbrg_pkg::S_IDLE;
          end
          default: tx_state <= astbrg_pkg::S_IDLE;
        endcase
      end
    end
  end

  always_comb begin
    case (tx_state)
      astbrg_pkg::S_START: next_serial_out = 1'b0;
      astbrg_pkg::S_DATA: next_serial_out = transmit_shift_register[0];
      astbrg_pkg::S_PAR: next_serial_out = tx_par;
      default: next_serial_out = 1'b1;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      SERIAL_OUT_PIN <= 1'b1;
      SERIAL_OUT_OE <= 1'b0;
    end else begin
      SERIAL_OUT_PIN <= next_serial_out;
      SERIAL_OUT_OE <= transmit_enable_bit;
    end
  end

  // transmit request pulse
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      TX_IRQ_REQ <= 1'b0;
    end else begin
      case (transmit_irq_mode)
        astbrg_pkg::TXI_EACH: TX_IRQ_REQ <= tx_pop;
        astbrg_pkg::TXI_DONE: TX_IRQ_REQ <= tx_done && tx_empty;
        astbrg_pkg::TXI_EMPTY: TX_IRQ_REQ <= tx_pop && (tx_count == 3'h1);
        default: TX_IRQ_REQ <= 1'b0;
      endcase
      if (transmit_enable_bit && !txen_q) TX_IRQ_REQ <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // receive path
  // ---------------------------------------------------------------
  astbrg_pkg::astbrg_state_t rx_state;
  astbrg_pkg::astbrg_rx_entry_t rx_dout;
  astbrg_pkg::astbrg_rx_entry_t rx_word;
  logic [2:0] rx_sync;
  logic rx_line;
  logic [4:0] rx_phase;
  logic [3:0] rx_bit;
  logic [8:0] rx_shift;
  logic rx_perr;
  logic rx_ferr;
  logic rx_stop2;
  logic rx_last;
  logic rx_end;
  logic rx_keep;
  logic rx_full;
  logic rx_empty;
  logic rx_pop;

  // line level moves only when the two later stages agree
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rx_sync <= 3'b111;
      rx_line <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], SERIAL_IN_PIN};
      if (rx_sync[1] == rx_sync[2]) rx_line <= rx_sync[2];
    end
  end

  assign rx_last = tick && (rx_phase == osr - 5'h01);
  assign rx_end = rx_last && (rx_state == astbrg_pkg::S_STOP) &&
                  (!mode.stop_count_select || rx_stop2);
  assign rx_keep = !(nine && adden && !rx_shift[8]);
  assign rx_ovf = rx_end && rx_keep && rx_full;
  assign rx_word = '{perr: rx_perr, ferr: rx_ferr || !rx_line, data: rx_shift};
  assign rx_pop = rd_go && (S_AXI_ARADDR == astbrg_pkg::OFS_RXDATA);

  astbrg_fifo #(
    .W(11)
  ) u_rx_fifo (
    .clk(CLK_SYS),
    .rst(RST),
    .clr(1'b0),
    .push(rx_end && rx_keep),
    .din(rx_word),
    .pop(rx_pop),
    .dout(rx_dout),
    .full(rx_full),
    .empty(rx_empty),
    .count()
  );

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rx_state <= astbrg_pkg::S_IDLE;
      rx_phase <= 5'h00;
      rx_bit <= 4'h0;
      rx_shift <= 9'h000;
      rx_perr <= 1'b0;
      rx_ferr <= 1'b0;
      rx_stop2 <= 1'b0;
    end else if (rx_state == astbrg_pkg::S_IDLE) begin
      if (!rx_line) begin
        rx_state <= astbrg_pkg::S_START;
        rx_phase <= 5'h00;
      end
    end else if (tick) begin
      rx_phase <= rx_last ? 5'h00 : rx_phase + 5'h01;
      case (rx_state)
        astbrg_pkg::S_START: begin
          // half a bit in: a high line means a glitch, not a start
          if (rx_phase == (osr >> 1) - 5'h01) begin
            rx_phase <= 5'h00;
            rx_bit <= 4'h0;
            rx_perr <= 1'b0;
            rx_ferr <= 1'b0;
            rx_stop2 <= 1'b0;
            rx_state <= rx_line ? astbrg_pkg::S_IDLE : astbrg_pkg::S_DATA;
          end
        end
        astbrg_pkg::S_DATA: if (rx_last) begin
          rx_shift <= nine ? {rx_line, rx_shift[8:1]} : {1'b0, rx_line, rx_shift[7:1]};
          rx_bit <= rx_bit + 4'h1;
          if (rx_bit == (nine ? 4'h8 : 4'h7)) begin
            rx_state <= has_par ? astbrg_pkg::S_PAR : astbrg_pkg::S_STOP;
          end
        end
        astbrg_pkg::S_PAR: if (rx_last) begin
          rx_perr <= (rx_line != par_of(rx_shift[7:0], mode.parity_data_select));
          rx_state <= astbrg_pkg::S_STOP;
        end
        astbrg_pkg::S_STOP: if (rx_last) begin
          rx_stop2 <= 1'b1;
          if (!rx_line) rx_ferr <= 1'b1;
          if (rx_end) rx_state <= astbrg_pkg::S_IDLE;
        end
        default: rx_state <= astbrg_pkg::S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    case (S_AXI_ARADDR)
      astbrg_pkg::OFS_MODE: rd_val[astbrg_pkg::MODE_HS:astbrg_pkg::MODE_STOP] = mode;
      astbrg_pkg::OFS_STATUS: begin
        rd_val[astbrg_pkg::STA_IRQM_HI] = transmit_irq_mode[1];
        rd_val[astbrg_pkg::STA_IRQM_LO] = transmit_irq_mode[0];
        rd_val[astbrg_pkg::STA_TXEN] = transmit_enable_bit;
        rd_val[astbrg_pkg::STA_TXBF] = tx_full;
        rd_val[astbrg_pkg::STA_TRMT] = tx_empty && (tx_state == astbrg_pkg::S_IDLE);
        rd_val[astbrg_pkg::STA_ADDEN] = adden;
        rd_val[astbrg_pkg::STA_RIDLE] = (rx_state == astbrg_pkg::S_IDLE);
        rd_val[astbrg_pkg::STA_PERR] = !rx_empty && rx_dout.perr;
        rd_val[astbrg_pkg::STA_FERR] = !rx_empty && rx_dout.ferr;
        rd_val[astbrg_pkg::STA_OERR] = oerr;
        rd_val[astbrg_pkg::STA_RXDA] = !rx_empty;
      end
      astbrg_pkg::OFS_RXDATA: rd_val[8:0] = rx_empty ? 9'h000 : rx_dout.data;
      astbrg_pkg::OFS_DIVISOR: rd_val[15:0] = baud_divisor;
      default: rd_val = 32'h0000_0000;
    endcase
  end

endmodule : astbrg_top

/* testbench/astbrg_monitor.sv */
// Purpose: port checks for the serial transceiver
// Assumes: one clock, reset active high
// Notes: bound to astbrg_top below
`timescale 1ns/10ps
module astbrg_monitor (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic SERIAL_OUT_PIN,
  input wire logic SERIAL_OUT_OE,
  input wire logic TX_IRQ_REQ
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_b_after: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |=> ##1 S_AXI_BVALID) else $error("no write response");
  a_r_after: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("no read answer");
  a_irq_pulse: assert property (TX_IRQ_REQ |=> !TX_IRQ_REQ)
    else $error("request longer than a cycle");
  a_enable_irq: assert property ($rose(SERIAL_OUT_OE) |-> ##[0:2] TX_IRQ_REQ)
    else $error("no request on enable");
  a_off_idle: assert property (!SERIAL_OUT_OE && !$past(SERIAL_OUT_OE, 2) |-> SERIAL_OUT_PIN)
    else $error("line not idle when off");
  a_bit_min: assert property ($fell(SERIAL_OUT_PIN) && SERIAL_OUT_OE
    |=> (!SERIAL_OUT_PIN || !SERIAL_OUT_OE)[*3])
    else $error("low bit too short");
  cover property (TX_IRQ_REQ);
  cover property (S_AXI_BVALID && S_AXI_BRESP == astbrg_pkg::RESP_SLVERR);
  cover property ($fell(SERIAL_OUT_PIN) && SERIAL_OUT_OE);
endmodule : astbrg_monitor

bind astbrg_top astbrg_monitor mon (.*);

/* testbench/astbrg_node.sv */
// Purpose: remote serial node on the line side
// Assumes: bench sets the bit length in clock cycles
// Notes: grabs 12 bit times per frame, line idles high
`timescale 1ns/10ps
module astbrg_node (
  input wire logic clk,
  input wire logic tx,
  input wire logic oe,
  output logic rx
);
  int bl = 16;
  logic [11:0] q[$];
  logic [11:0] f;
  initial rx = 1'b1;
  // sample on the falling clock so the design's edge updates have landed
  initial forever begin
    @(negedge tx);
    if (oe) begin
      repeat (bl / 2) @(negedge clk);
      for (int i = 0; i < 12; i++) begin
        if (i > 0) repeat (bl) @(negedge clk);
        f[i] = tx;
      end
      q.push_back(f);
    end
  end
  // last bit sent is a stop, so the line is left high
  task automatic send(input logic [11:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      rx <= b[i];
      repeat (bl) @(posedge clk);
    end
  endtask : send
endmodule : astbrg_node

/* testbench/async_serial_transceiver_brg_tb.sv */
// Purpose: self-checking bench for the serial transceiver
// Assumes: AXI4-Lite master tasks, node model on the line
// Notes: random frames from a fixed seed plus hand-picked cases
`timescale 1ns/10ps
module async_serial_transceiver_brg_tb;
  logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, got, r;
  logic [31:0] seed = 32'h5d948fac;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, sout, oe, irq, sin;
  logic [1:0] bresp, rresp, resp;
  int bad_count = 0, checked = 0, irqs = 0;
  initial forever #5 clk = ~clk;
  astbrg_top dut (.CLK_SYS(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .SERIAL_IN_PIN(sin), .SERIAL_OUT_PIN(sout), .SERIAL_OUT_OE(oe), .TX_IRQ_REQ(irq));
  astbrg_node node (.clk(clk), .tx(sout), .oe(oe), .rx(sin));
  always @(negedge clk) if (irq === 1'b1) irqs++;
  // -----------------------------------------
  // helpers
  // -----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // frame bits, start first; top nibble holds the length
  function automatic logic [15:0] fr(input logic [8:0] d, input logic [1:0] p,
    input logic s, input logic [1:0] bad);
    logic [11:0] f;
    int n;
    f = 12'hffe;
    n = (p == 2'b11) ? 9 : 8;
    for (int k = 0; k < n; k++) f[k + 1] = d[k];
    n++;
    if (^p) begin
      f[n] = ^d[7:0] ^ p[1] ^ bad[0];
      n++;
    end
    if (s) f[n] = ~bad[1];
    return {4'(n + 1 + s), f};
  endfunction : fr
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // ready is sampled mid-cycle, the release lands on the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      resp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ta = arready;
      tr = rvalid;
      got = rdata;
      resp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
  endtask : rd
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
  // -----------------------------------------
  // scenarios
  // -----------------------------------------
  initial begin
    logic [15:0] fw;
    logic [3:0] m;
    logic [1:0] bad;
    logic [7:0] ov[5];
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(astbrg_pkg::OFS_MODE);
    chk(got, 32'h0);
    rd(8'h14);
    chk({30'h0, resp}, {30'h0, astbrg_pkg::RESP_SLVERR});
    wr(8'h20, 32'h0);
    chk({30'h0, resp}, {30'h0, astbrg_pkg::RESP_SLVERR});
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      m = {r[4], i[1:0], i[2]};
      node.bl = (r[4] ? 4 : 16) * (r[1:0] + 1);
      wr(astbrg_pkg::OFS_MODE, {28'h0, m});
      wr(astbrg_pkg::OFS_DIVISOR, {30'h0, r[1:0]});
      irqs = 0;
      wr(astbrg_pkg::OFS_STATUS, {16'h0, i[0], 1'b0, i[2], 2'b00, 1'b1, 4'h0, 1'b1, 5'h0});
      wr(astbrg_pkg::OFS_TXDATA, {23'h0, r[16:8]});
      fw = fr(r[16:8], m[2:1], m[0], 2'b00);
      while (node.q.size() == 0) @(posedge clk);
      chk(node.q.pop_front(), fw[11:0]);
      repeat (node.bl + 4) @(posedge clk);
      chk(irqs, (i[0] & i[2]) ? 1 : 2);
      bad = r[21:20] & {m[0], ^m[2:1]};
      fw = fr({i[2], r[29:22]}, m[2:1], m[0], bad);
      node.send(fw[11:0], fw[15:12]);
      repeat (2 * node.bl) @(posedge clk);
      rd(astbrg_pkg::OFS_STATUS);
      chk(got & 32'hf, {28'h0, bad[0], bad[1], 1'b0, i != 3});
      rd(astbrg_pkg::OFS_RXDATA);
      chk(got, (i == 3) ? 0 : {23'h0, m[2] & m[1] & i[2], r[29:22]});
      wr(astbrg_pkg::OFS_STATUS, 32'h0);
    end
    // queue four while off, then enable
    wr(astbrg_pkg::OFS_MODE, 32'h7);
    wr(astbrg_pkg::OFS_DIVISOR, 32'h0);
    node.bl = 16;
    for (int k = 0; k < 4; k++) wr(astbrg_pkg::OFS_TXDATA, 32'h1a5 + k);
    rd(astbrg_pkg::OFS_STATUS);
    chk(got & 32'h300, 32'h200);
    wr(astbrg_pkg::OFS_STATUS, 32'h400);
    fw = fr(9'h1a5, 2'b11, 1'b1, 2'b00);
    while (node.q.size() == 0) @(posedge clk);
    chk(node.q.pop_front(), fw[11:0]);
    wr(astbrg_pkg::OFS_STATUS, 32'h0);
    rd(astbrg_pkg::OFS_STATUS);
    chk(got & 32'h700, 32'h100);
    repeat (300) @(posedge clk);
    node.q.delete();
    // five arrivals into a four-entry queue
    wr(astbrg_pkg::OFS_MODE, 32'h0);
    for (int k = 0; k < 5; k++) begin
      r = rnd();
      ov[k] = r[7:0];
      fw = fr({1'b0, r[7:0]}, 2'b00, 1'b0, 2'b00);
      node.send(fw[11:0], 10);
    end
    repeat (40) @(posedge clk);
    rd(astbrg_pkg::OFS_STATUS);
    chk(got & 32'h3, 32'h3);
    for (int k = 0; k < 4; k++) begin
      rd(astbrg_pkg::OFS_RXDATA);
      chk(got, {24'h0, ov[k]});
    end
    print_verdict();
  end
endmodule : async_serial_transceiver_brg_tb
